// ### hdl/wrb_defs.svh
// timing counts and bit positions for the wake, reset and boot sequencer
`ifndef WRB_DEFS_SVH
`define WRB_DEFS_SVH
// clock rate in kHz and period in ns
`define WRB_CLK_KHZ 10000
`define WRB_CLK_NS 100
// wake hold time in microseconds, and the cycles it takes (least time, rounded up)
`define WRB_WAKE_HOLD_US 3000
`define WRB_WAKE_HOLD_CYC ((`WRB_WAKE_HOLD_US * 1000 + `WRB_CLK_NS - 1) / `WRB_CLK_NS)
// ready-to-answer budget in milliseconds, in cycles (longest time, rounded down)
`define WRB_READY_MS 100
`define WRB_READY_CYC ((`WRB_READY_MS * `WRB_CLK_KHZ))
// bit position of the connect bit in the usb control register
`define WRB_CONNECT_BIT 7
// reset value of the usb control register
`define WRB_USB_CONTROL_REGISTER_RST 8'h00
// endpoint counts besides endpoint zero
`define WRB_IN_EPS 3
`define WRB_OUT_EPS 3
`endif

// ### hdl/wrb_pkg.sv
// types for the wake, reset and boot sequencer
package wrb_pkg;
    // one-hot boot and power states
    typedef enum logic [6:0] {
        WRB_PROBE = 7'b0000001,
        WRB_LOAD = 7'b0000010,
        WRB_CONNECT = 7'b0000100,
        WRB_RUN = 7'b0001000,
        WRB_RECONN = 7'b0010000,
        WRB_SUSPEND = 7'b0100000,
        WRB_CONFIRM = 7'b1000000
    } wrb_state_t;
endpackage : wrb_pkg

// ### hdl/wrb_sync.sv
// two-stage synchroniser for one level
`timescale 1ns/1ps
`default_nettype none
module wrb_sync (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic async_in,
    input wire logic rst_val,
    output logic sync_out
);
    logic meta;
    // first stage feeds only the second; rst_val inverts the input, both stages reset to zero
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            meta <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta <= async_in ^ rst_val;
            sync_out <= meta;
        end
    end
endmodule : wrb_sync
`default_nettype wire

// ### hdl/wrb_sequencer.sv
// wake detection, reset handling and boot sequencing for the usb bridge
//
// Summary of operation
// - Suspend is left on a host wake command or a local remote-wakeup event.
// - Low pulse on wake pin or rising ring indicate edge requests remote wakeup.
// - Clock stops in suspend; wake inputs are sampled after restart to confirm.
// - Within 100 ms of reset the device should be loaded and answering the host; a miss is only flagged on ready_late.
// - After any reset the connect bit is clear, device disconnected.
// - Valid eeprom code is copied to program ram, then connect is set.
// - No valid eeprom code: connect is set directly for default enumeration.
// - After host download firmware clears then sets connect, forcing re-enumeration.
// - Endpoint zero controls; up to three in and three out bulk/interrupt endpoints.
`timescale 1ns/1ps
`default_nettype none
`include "wrb_defs.svh"
module wrb_sequencer
    import wrb_pkg::*;
#(
    parameter int unsigned WAKE_HOLD_CYC = `WRB_WAKE_HOLD_CYC,
    parameter int unsigned READY_CYC = `WRB_READY_CYC
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic wake_req_n,
    input wire logic ring_indicate_input,
    input wire logic host_resume,
    input wire logic host_suspend,
    input wire logic probe_done,
    input wire logic probe_valid,
    input wire logic load_done,
    input wire logic fw_reconnect,
    input wire logic [3:0] ep_in_enable,
    input wire logic [3:0] ep_out_enable,
    output logic probe_start,
    output logic load_start,
    output logic [7:0] usb_control_register,
    output logic usb_connect_bit,
    output logic xtal_power_down,
    output logic suspended,
    output logic ready_late,
    output logic [3:0] ep_in_active,
    output logic [3:0] ep_out_active
);
    wrb_state_t state, next_state;
    logic wake_lo, ri_hi, ri_prev;
    logic [31:0] hold_cnt, next_hold_cnt;
    logic [31:0] ready_cnt;
    logic ready_seen;
    logic probe_issued;

    // wake pin is active low: the synchroniser inverts it so wake_lo=1 means low
    wrb_sync u_sync_wake (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .async_in(wake_req_n),
        .rst_val(1'b1),
        .sync_out(wake_lo)
    );
    wrb_sync u_sync_ri (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .async_in(ring_indicate_input),
        .rst_val(1'b0),
        .sync_out(ri_hi)
    );

    // remote wake conditions seen only after the synchroniser
    wire ri_rise = ri_hi & ~ri_prev;
    wire wake_cond = wake_lo | ri_hi;
    wire local_wake = wake_lo | ri_rise;
    // the hold count only starts once the synchronised condition is seen, so the
    // board must keep the wake source up one cycle beyond the hold time itself;
    // a shorter pulse falls back to suspend and is simply lost
    wire hold_met = (hold_cnt >= WAKE_HOLD_CYC - 1);
    wire in_boot = (state == WRB_PROBE) | (state == WRB_LOAD) | (state == WRB_CONNECT);

    // endpoint zero follows connect one cycle later; at most three more each way
    // bit zero of the enables is ignored so a careless host cannot drop control
    wire [3:0] next_ep_in = {ep_in_enable[3:1], 1'b1};
    wire [3:0] next_ep_out = {ep_out_enable[3:1], 1'b1};

    // next-state decode
    // host resume wins over a local wake, and a local wake is only a candidate
    // until the confirm state has seen it held; probe and load strobes come
    // from the loader and are ignored in any other state
    always_comb begin
        next_state = state;
        next_hold_cnt = '0;
        unique case (state)
            WRB_PROBE: begin
                if (probe_done) begin
                    next_state = probe_valid ? WRB_LOAD : WRB_CONNECT;
                end
            end
            WRB_LOAD: begin
                if (load_done) begin
                    next_state = WRB_CONNECT;
                end
            end
            WRB_CONNECT: begin
                next_state = WRB_RUN;
            end
            WRB_RUN: begin
                if (host_suspend) begin
                    next_state = WRB_SUSPEND;
                end else if (fw_reconnect) begin
                    next_state = WRB_RECONN;
                end
            end
            WRB_RECONN: begin
                next_state = WRB_CONNECT;
            end
            WRB_SUSPEND: begin
                if (host_resume) begin
                    next_state = WRB_RUN;
                end else if (local_wake) begin
                    next_state = WRB_CONFIRM;
                end
            end
            WRB_CONFIRM: begin
                // condition must persist while the restarted clock counts
                if (host_resume) begin
                    next_state = WRB_RUN;
                end else if (!wake_cond) begin
                    next_state = WRB_SUSPEND;
                end else if (hold_met) begin
                    next_state = WRB_RUN;
                end else begin
                    next_hold_cnt = hold_cnt + 32'd1;
                end
            end
            default: begin
                next_state = WRB_PROBE;
            end
        endcase
    end

    // state and edge history
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state <= WRB_PROBE;
            hold_cnt <= '0;
            ri_prev <= 1'b0;
        end else begin
            state <= next_state;
            hold_cnt <= next_hold_cnt;
            ri_prev <= ri_hi;
        end
    end

    // connect is up in every state except probe, load and the reconnect cycle;
    // suspend keeps it up, since the host still owns the session while asleep
    wire connect_next = (next_state != WRB_PROBE) & (next_state != WRB_LOAD)
        & (next_state != WRB_RECONN);

    // connect bit: cleared by reset and by a reconnect, set when code is ready
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            usb_control_register <= `WRB_USB_CONTROL_REGISTER_RST;
            usb_connect_bit <= 1'b0;
        end else begin
            usb_control_register[`WRB_CONNECT_BIT] <= connect_next;
            usb_connect_bit <= connect_next;
        end
    end

    // one probe request per boot; a request that kept toggling would restart
    // a slow memory in mid-answer, so a flag remembers that it went out
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            probe_issued <= 1'b0;
        end else begin
            probe_issued <= (state == WRB_PROBE) & (probe_issued | probe_start);
        end
    end

    // strobes to the eeprom loader, crystal control and status
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            probe_start <= 1'b0;
            load_start <= 1'b0;
            xtal_power_down <= 1'b0;
            suspended <= 1'b0;
            ep_in_active <= 4'h0;
            ep_out_active <= 4'h0;
        end else begin
            probe_start <= (state == WRB_PROBE) & ~ready_seen & ~probe_issued
                & ~probe_start & ~probe_done;
            load_start <= (state == WRB_PROBE) & probe_done & probe_valid;
            xtal_power_down <= (next_state == WRB_SUSPEND);
            suspended <= (next_state == WRB_SUSPEND) | (next_state == WRB_CONFIRM);
            ep_in_active <= usb_connect_bit ? next_ep_in : 4'h0;
            ep_out_active <= usb_connect_bit ? next_ep_out : 4'h0;
        end
    end

    // ready budget watch: flags if connect is not up in time; it only reports
    // the counter saturates at the budget so a hung loader cannot wrap it back
    // to a quiet value; a reconnect later does not restart the budget
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ready_cnt <= '0;
            ready_seen <= 1'b0;
            ready_late <= 1'b0;
        end else begin
            if (!in_boot) begin
                ready_seen <= 1'b1;
            end
            if (in_boot && !ready_seen && ready_cnt < READY_CYC) begin
                ready_cnt <= ready_cnt + 32'd1;
            end
            ready_late <= ready_late | (in_boot & ~ready_seen & (ready_cnt >= READY_CYC));
        end
    end
endmodule : wrb_sequencer
`default_nettype wire

// ### test/wrb_sequencer_asserts.sv
// port assertions for the wake, reset and boot sequencer
`timescale 1ns/1ps
`default_nettype none
module wrb_sequencer_asserts #(
    parameter int unsigned WAKE_HOLD_CYC = 8
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic wake_req_n, ring_indicate_input, host_resume,
    input wire logic probe_done, probe_valid, load_done, fw_reconnect, probe_start,
    input wire logic [3:0] ep_in_enable,
    input wire logic [7:0] usb_control_register,
    input wire logic usb_connect_bit, suspended,
    input wire logic [3:0] ep_in_active
);
    // local wake as one level; ring edge stays high while held
    wire wake_cond = !wake_req_n | ring_indicate_input;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    chk_reset_clear: assert property ($rose(rstn) |-> usb_control_register == 8'h00)
        else $error("control not clear after reset");
    chk_direct_conn: assert property (probe_done && !probe_valid |-> ##[1:2] usb_connect_bit)
        else $error("no connect without code");
    chk_load_conn: assert property (load_done && !usb_connect_bit |-> ##[1:2] usb_connect_bit)
        else $error("no connect after copy");
    chk_reconn_gap: assert property (fw_reconnect && usb_connect_bit && !suspended
        |=> ##[0:1] !usb_connect_bit ##1 usb_connect_bit) else $error("reconnect gap");
    chk_ep_follow: assert property (usb_connect_bit |=> ep_in_active == (ep_in_enable | 4'h1))
        else $error("endpoints wrong");
    chk_host_wake: assert property (suspended && host_resume |-> ##[1:2] !suspended)
        else $error("host wake ignored");
    chk_wake_held: assert property ($fell(suspended) && !$past(host_resume)
        && !$past(host_resume, 2) |-> $past(wake_cond, WAKE_HOLD_CYC)) else $error("short wake");
    chk_sync_delay: assert property (suspended && !host_resume && $rose(wake_cond)
        |=> suspended [*2]) else $error("wake not synchronised");
    chk_probe_once: assert property (probe_start |=> !probe_start [*2])
        else $error("probe request repeated");
    cover property (fw_reconnect && usb_connect_bit);
    cover property ($fell(suspended));
    cover property (probe_done && probe_valid);
endmodule : wrb_sequencer_asserts
bind wrb_sequencer wrb_sequencer_asserts #(.WAKE_HOLD_CYC(WAKE_HOLD_CYC)) u_chk (
    .ref_clk, .rstn, .wake_req_n, .ring_indicate_input, .host_resume, .probe_done,
    .probe_valid, .load_done, .fw_reconnect, .probe_start, .ep_in_enable, .usb_control_register,
    .usb_connect_bit, .suspended, .ep_in_active
);
`default_nettype wire

// ### test/wrb_eeprom_model.sv
// serial eeprom stand-in answering probe and copy requests
`timescale 1ns/1ps
`default_nettype none
module wrb_eeprom_model (
    input wire logic ref_clk,
    input wire logic probe_start, load_start, code_ok, load_hang,
    input wire logic [3:0] delay,
    output logic probe_done,
    output logic probe_valid,
    output logic load_done
);
    initial begin
        probe_done = 0;
        probe_valid = 0;
        load_done = 0;
    end
    // valid is only meaningful with done, so it lies outside the pulse
    always @(negedge ref_clk) begin
        if (probe_start) begin
            repeat (delay) @(negedge ref_clk);
            probe_valid = code_ok;
            probe_done = 1;
            @(negedge ref_clk);
            probe_done = 0;
            probe_valid = !code_ok;
        end
    end
    // a hung memory never finishes the copy
    always @(negedge ref_clk) begin
        if (load_start && !load_hang) begin
            repeat (delay) @(negedge ref_clk);
            load_done = 1;
            @(negedge ref_clk);
            load_done = 0;
        end
    end
endmodule : wrb_eeprom_model
`default_nettype wire

// ### test/wrb_sequencer_bench.sv
// self-checking bench for the wake, reset and boot sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
    begin \
        num_checks++; \
        if ((g) !== (e)) begin \
            errors++; \
            $display("[ERR] %0t got %0h", $time, g); \
        end \
    end
module wrb_sequencer_bench;
    localparam int HOLD = 8;
    localparam int READY = 50;
    int errors = 0;
    int num_checks = 0;
    logic ref_clk = 0, rstn = 0, wake_req_n = 1, ring_indicate_input = 0;
    logic host_resume = 0, host_suspend = 0, fw_reconnect = 0, code_ok = 0, load_hang = 0;
    logic [3:0] delay = 4'h0;
    logic probe_done, probe_valid, load_done, probe_start, load_start;
    logic usb_connect_bit, suspended, xtal_power_down, ready_late;
    logic [7:0] usb_control_register;
    logic [3:0] ep_in_active, ep_out_active;
    always #50 ref_clk = ~ref_clk;
    wrb_sequencer #(.WAKE_HOLD_CYC(HOLD), .READY_CYC(READY)) dut (
        .ref_clk, .rstn, .wake_req_n, .ring_indicate_input, .host_resume, .host_suspend,
        .probe_done, .probe_valid, .load_done, .fw_reconnect, .ep_in_enable(4'ha),
        .ep_out_enable(4'h6), .probe_start, .load_start, .usb_control_register,
        .usb_connect_bit, .xtal_power_down, .suspended, .ready_late, .ep_in_active,
        .ep_out_active
    );
    wrb_eeprom_model eep (.ref_clk, .probe_start, .load_start, .code_ok, .load_hang,
        .delay, .probe_done, .probe_valid, .load_done);
    task automatic pulse(ref logic s);
        s = 1;
        @(negedge ref_clk);
        s = 0;
    endtask : pulse
    // reset, then wait a bounded time for connect
    task automatic boot(input logic ok, input logic hang, input logic [3:0] d);
        int n;
        code_ok = ok;
        load_hang = hang;
        delay = d;
        rstn = 0;
        repeat (2) @(negedge ref_clk);
        `CHK(usb_connect_bit, 1'b0)
        rstn = 1;
        for (n = 0; n < 40 && usb_connect_bit !== 1'b1; n++) @(negedge ref_clk);
    endtask : boot
    task automatic t_host_boot;
        boot(0, 0, 4'h0);
        `CHK(usb_control_register, 8'h80)
        @(negedge ref_clk);
        `CHK(ep_in_active, 4'hb)
        `CHK(ep_out_active, 4'h7)
    endtask : t_host_boot
    task automatic t_reconnect;
        int lows = 0;
        pulse(fw_reconnect);
        repeat (5) begin
            lows += !usb_connect_bit;
            @(negedge ref_clk);
        end
        `CHK(lows, 1)
    endtask : t_reconnect
    task automatic go_suspend;
        pulse(host_suspend);
        repeat (3) @(negedge ref_clk);
        `CHK(xtal_power_down, 1'b1)
        `CHK(usb_connect_bit, 1'b1)
    endtask : go_suspend
    // early release must not wake; wake sources held long enough do
    task automatic t_wake;
        go_suspend();
        wake_req_n = 0;
        repeat (HOLD - 4) @(negedge ref_clk);
        wake_req_n = 1;
        repeat (4) @(negedge ref_clk);
        `CHK(suspended, 1'b1)
        wake_req_n = 0;
        repeat (HOLD + 6) @(negedge ref_clk);
        wake_req_n = 1;
        `CHK(suspended, 1'b0)
        go_suspend();
        ring_indicate_input = 1;
        repeat (HOLD + 6) @(negedge ref_clk);
        ring_indicate_input = 0;
        `CHK(xtal_power_down, 1'b0)
        go_suspend();
        pulse(host_resume);
        repeat (2) @(negedge ref_clk);
        `CHK(suspended, 1'b0)
    endtask : t_wake
    // prompt and slow memories, then one that never finishes
    task automatic t_eeprom_boot;
        for (int d = 0; d < 12; d += 11) begin
            boot(1, 0, d[3:0]);
            `CHK(usb_connect_bit, 1'b1)
            `CHK(ready_late, 1'b0)
        end
        boot(1, 1, 4'h0);
        repeat (READY) @(negedge ref_clk);
        `CHK(usb_connect_bit, 1'b0)
        `CHK(ready_late, 1'b1)
    endtask : t_eeprom_boot
    initial begin
        t_host_boot();
        t_reconnect();
        t_wake();
        t_eeprom_boot();
        final_report();
    end
    // whole run is a few hundred cycles
    initial begin
        repeat (5000) @(posedge ref_clk);
        errors++;
        final_report();
    end
    task automatic final_report;
        if (errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report
endmodule : wrb_sequencer_bench
`default_nettype wire
